// ===== ssrr_bus_if.sv
// Purpose: carries one decoded scratch access from the top to the storage module
// Assumes: one access per cycle
// Notes: none
`timescale 1ns/10ps
interface ssrr_bus_if;
  import ssrr_pkg::*;
  ssrr_op_t op;
  logic [1:0] idx;
  logic [2:0] bit_sel;
  logic [7:0] wdata;
  logic [31:0] all_bytes;
  modport ctrl (output op, output idx, output bit_sel, output wdata, input all_bytes);
  modport store (input op, input idx, input bit_sel, input wdata, output all_bytes);
endinterface : ssrr_bus_if

// ===== ssrr_consts.svh
// Purpose: offsets, reset values and layout constants for the scratch and revision bank
// Assumes: byte-wide registers on the processor i/o bus
// Notes: included by its bare name
`ifndef SSRR_CONSTS_SVH
`define SSRR_CONSTS_SVH
`define SSRR_SCR_OFS_0 8'h00
`define SSRR_SCR_OFS_3 8'h03
`define SSRR_REV_RSVD_OFS 8'h00
`define SSRR_REV_OFS 8'h01
`define SSRR_SCR_RESET 8'h00
`define SSRR_RSVD_READ 8'h00
`define SSRR_FIRST_REV 8'h00
`endif

// ===== ssrr_pkg.sv
// Purpose: types for the scratch and revision bank
// Assumes: nothing
// Notes: access operations as seen on the i/o bus
package ssrr_pkg;
  typedef enum logic [2:0] {
    SSRR_OP_NONE = 3'h0,
    SSRR_OP_WRITE = 3'h1,
    SSRR_OP_SET_BIT = 3'h3,
    SSRR_OP_CLR_BIT = 3'h2,
    SSRR_OP_TEST_BIT = 3'h6
  } ssrr_op_t;
endpackage : ssrr_pkg

// ===== ssrr_scratch.sv
// Purpose: four scratch bytes with byte write and single-bit set and clear
// Assumes: synchronous reset
// Notes: a bit op touches only the addressed bit
`timescale 1ns/10ps
`include "ssrr_consts.svh"
module ssrr_scratch
  import ssrr_pkg::*;
#(
  parameter int NUM_BYTES = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // access port
  ssrr_bus_if.store bus
);
  logic [7:0] mem_q [NUM_BYTES];
  logic [7:0] mem_d [NUM_BYTES];

  genvar g;
  generate
    for (g = 0; g < NUM_BYTES; g++) begin : g_byte
      always_comb begin
        mem_d[g] = mem_q[g];
        if (bus.idx == 2'(g)) begin
          case (bus.op)
            SSRR_OP_WRITE: mem_d[g] = bus.wdata;
            SSRR_OP_SET_BIT: mem_d[g] = mem_q[g] | (8'h01 << bus.bit_sel);
            SSRR_OP_CLR_BIT: mem_d[g] = mem_q[g] & ~(8'h01 << bus.bit_sel);
            default: mem_d[g] = mem_q[g];
          endcase
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          mem_q[g] <= `SSRR_SCR_RESET;
        end else begin
          mem_q[g] <= mem_d[g];
        end
      end
      assign bus.all_bytes[8*g +: 8] = mem_q[g];
    end
  endgenerate
endmodule : ssrr_scratch

// ===== ssrr_top.sv
// Purpose: scratch byte bank and read-only silicon revision register
// Assumes: byte-wide processor i/o port, one access per cycle, synchronous inputs
// Notes: read data and bit test result are registered, valid one cycle after the request
//
// Summary of operation
// - four 8-bit scratch bytes keep last write
// - scratch bytes at offsets zero to three
// - single-bit set, clear and test supported
// - revision at offset one, read-only
// - revision counts up from zero per letter
`timescale 1ns/10ps
`include "ssrr_consts.svh"
module ssrr_top
  import ssrr_pkg::*;
#(
  parameter logic [7:0] SILICON_REV = `SSRR_FIRST_REV
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // scratch byte access
  input wire logic i_scr_sel,
  input wire logic [7:0] i_scr_addr,
  input wire logic i_scr_wr,
  input wire logic i_scr_rd,
  input wire logic i_scr_set_bit,
  input wire logic i_scr_clr_bit,
  input wire logic i_scr_test_bit,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_wdata,
  // system info block access
  input wire logic i_info_sel,
  input wire logic [7:0] i_info_addr,
  input wire logic i_info_rd,
  // answers
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_bit_val
);
  ssrr_bus_if bus ();

  logic scr_hit;
  logic [7:0] rdata_d, rdata_q;
  logic rvalid_d, rvalid_q;
  logic bit_d, bit_q;
  logic [7:0] cur_byte;

  // out-of-range offsets simply miss; they neither store nor answer with data
  assign scr_hit = i_scr_sel && (i_scr_addr <= `SSRR_SCR_OFS_3);

  always_comb begin
    bus.op = SSRR_OP_NONE;
    bus.idx = i_scr_addr[1:0];
    bus.bit_sel = i_bit_sel;
    bus.wdata = i_wdata;
    if (scr_hit) begin
      if (i_scr_wr) begin
        bus.op = SSRR_OP_WRITE;
      end else if (i_scr_set_bit) begin
        bus.op = SSRR_OP_SET_BIT;
      end else if (i_scr_clr_bit) begin
        bus.op = SSRR_OP_CLR_BIT;
      end else begin
        bus.op = SSRR_OP_NONE;
      end
    end
  end

  ssrr_scratch #(.NUM_BYTES(4)) u_scratch (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .bus(bus)
  );

  assign cur_byte = bus.all_bytes[8*i_scr_addr[1:0] +: 8];

  always_comb begin
    rdata_d = 8'h00;
    rvalid_d = 1'b0;
    bit_d = bit_q;
    if (scr_hit && i_scr_rd) begin
      rdata_d = cur_byte;
      rvalid_d = 1'b1;
    end else if (scr_hit && i_scr_test_bit) begin
      bit_d = cur_byte[i_bit_sel];
      rvalid_d = 1'b1;
      rdata_d = cur_byte;
    end else if (i_info_sel && i_info_rd) begin
      rvalid_d = 1'b1;
      if (i_info_addr == `SSRR_REV_OFS) begin
        rdata_d = SILICON_REV;
      end else begin
        rdata_d = `SSRR_RSVD_READ;
      end
    end
  end

  // the info block has no write path at all, so writes there cannot land
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      bit_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      bit_q <= bit_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_bit_val = bit_q;
endmodule : ssrr_top

// ===== ssrr_top_asserts.sv
// Purpose: port checks for the scratch and revision bank
// Assumes: one access per cycle
// Notes: bound to the top
`timescale 1ns/10ps
module ssrr_asserts #(parameter logic [7:0] SILICON_REV = 8'h00) (
  input wire logic i_clk, i_srst, i_scr_sel, i_scr_wr, i_scr_rd,
  input wire logic i_scr_set_bit, i_scr_clr_bit, i_scr_test_bit, i_info_sel, i_info_rd,
  input wire logic [7:0] i_scr_addr, i_wdata, i_info_addr, o_rdata,
  input wire logic [2:0] i_bit_sel,
  input wire logic o_rvalid, o_bit_val
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  logic info_q;
  // scratch reads win over the info block
  assign info_q = i_info_sel && i_info_rd && !(i_scr_sel && (i_scr_rd || i_scr_test_bit));
  sequence s_wr; i_scr_sel && i_scr_wr && i_scr_addr < 8'h04; endsequence
  sequence s_rd; i_scr_sel && i_scr_rd && i_scr_addr == $past(i_scr_addr); endsequence
  a_wr_rd_back: assert property (s_wr ##1 s_rd |=> o_rdata == $past(i_wdata, 2))
    else $error("read after write wrong");
  a_rd_answer: assert property (i_scr_sel && i_scr_rd && i_scr_addr < 8'h04 |=> o_rvalid)
    else $error("read not answered");
  a_oor_silent: assert property (i_scr_sel && i_scr_addr > 8'h03 && !i_info_sel |=> !o_rvalid)
    else $error("out of range offset answered");
  a_bit_test: assert property (i_scr_sel && i_scr_test_bit && !i_scr_rd && i_scr_addr < 8'h04
    |=> o_bit_val == o_rdata[$past(i_bit_sel)]) else $error("bit test wrong");
  a_rev_value: assert property (info_q && i_info_addr == 8'h01 |=> o_rdata == SILICON_REV)
    else $error("revision wrong");
  a_rsvd_zero: assert property (info_q && i_info_addr == 8'h00 |=> o_rvalid && o_rdata == 8'h00)
    else $error("reserved not zero");
  a_reset_clear: assert property (disable iff (1'b0)
    i_srst |=> !o_rvalid && o_rdata == 8'h00 && !o_bit_val)
    else $error("reset not clean");
endmodule : ssrr_asserts
bind ssrr_top ssrr_asserts #(.SILICON_REV(SILICON_REV)) ssrr_asserts_inst (.*);

// ===== ssrr_top_tb.sv
// Purpose: directed bench for the scratch and revision bank
// Assumes: answer one cycle after the request
// Notes: revision set off zero so a stuck value shows
`timescale 1ns/10ps
module ssrr_top_tb;
  localparam logic [7:0] REV = 8'h02;
  logic i_clk = 1'b0, i_srst = 1'b1, i_scr_sel = 1'b0, i_scr_wr = 1'b0, i_scr_rd = 1'b0;
  logic i_scr_set_bit = 1'b0, i_scr_clr_bit = 1'b0, i_scr_test_bit = 1'b0;
  logic i_info_sel = 1'b0, i_info_rd = 1'b0, o_rvalid, o_bit_val;
  logic [7:0] i_scr_addr = 8'h00, i_wdata = 8'h00, i_info_addr = 8'h00, o_rdata;
  logic [2:0] i_bit_sel = 3'h0;
  int num_errors = 0, comparisons = 0;
  ssrr_top #(.SILICON_REV(REV)) ssrr_top_inst (.*);
  initial forever #2.5 i_clk = ~i_clk;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // k is {info rd, wr, rd, set, clr, test}
  task op(input logic [7:0] a, input logic [5:0] k, input logic [2:0] b, input logic [7:0] d);
    @(posedge i_clk);
    i_scr_sel <= |k[4:0];
    i_info_sel <= k[5];
    {i_info_rd, i_scr_wr, i_scr_rd, i_scr_set_bit, i_scr_clr_bit, i_scr_test_bit} <= k;
    i_scr_addr <= a;
    i_info_addr <= a;
    i_bit_sel <= b;
    i_wdata <= d;
  endtask : op
  task rd(input logic [7:0] a, input logic [5:0] k, input logic [2:0] b, input logic [7:0] e);
    op(a, k, b, 8'h00);
    op(8'h00, 6'h00, 3'h0, 8'h00);
    #1;
    chk({7'h00, o_rvalid}, 8'h01);
    chk(o_rdata, e);
  endtask : rd
  task print_verdict;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    for (int n = 0; n < 4; n++) rd(n[7:0], 6'h08, 3'h0, 8'h00);
    $display("reset values done");
    for (int n = 0; n < 4; n++) op(n[7:0], 6'h10, 3'h0, 8'hA0 + n[7:0]);
    // a wrapped offset would land in byte 0 and show up in the reads below
    op(8'h04, 6'h10, 3'h0, 8'hFF);
    for (int n = 3; n >= 0; n--) rd(n[7:0], 6'h08, 3'h0, 8'hA0 + n[7:0]);
    $display("byte access done");
    op(8'h01, 6'h04, 3'h6, 8'h00);
    op(8'h01, 6'h02, 3'h0, 8'h00);
    rd(8'h01, 6'h08, 3'h0, 8'hE0);
    rd(8'h01, 6'h01, 3'h7, 8'hE0);
    chk({7'h00, o_bit_val}, 8'h01);
    rd(8'h01, 6'h01, 3'h0, 8'hE0);
    chk({7'h00, o_bit_val}, 8'h00);
    op(8'h02, 6'h06, 3'h0, 8'h00);
    op(8'h03, 6'h14, 3'h0, 8'h5A);
    rd(8'h02, 6'h08, 3'h0, 8'hA3);
    rd(8'h03, 6'h08, 3'h0, 8'h5A);
    $display("bit access done");
    rd(8'h01, 6'h20, 3'h0, REV);
    rd(8'h00, 6'h20, 3'h0, 8'h00);
    $display("revision done");
    rd(8'h01, 6'h01, 3'h7, 8'hE0);
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    #1;
    chk({7'h00, o_bit_val}, 8'h00);
    for (int n = 0; n < 4; n++) rd(n[7:0], 6'h08, 3'h0, 8'h00);
    $display("mid-run reset done");
    print_verdict();
  end
endmodule : ssrr_top_tb
